// ===== dv/dsia_assembler_assertions.sv
// port checks for the status frame stream of the assembler
// assumes one clock domain and the port names of the top module
module dsia_assembler_assertions (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       poll,
   input wire logic       byte_valid,
   input wire logic       byte_ready,
   input wire logic [7:0] byte_data,
   input wire logic       byte_last,
   input wire logic       error_response,
   input wire logic [3:0] frame_len
);
   logic [3:0] idx;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // position of the byte on offer within its frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) idx <= 4'h0;
      else if (byte_valid && byte_ready) idx <= byte_last ? 4'h0 : idx + 4'h1;
   end
   len_legal_a: assert property (byte_valid |->
      frame_len inside {4'h4, 4'h6, 4'h8}) else $error("bad length");
   last_at_len_a: assert property (byte_valid |->
      byte_last == (idx == frame_len - 4'h1)) else $error("bad last");
   byte1_zero_a: assert property (byte_valid && idx == 4'h1 |->
      byte_data == 8'h00) else $error("byte1 set");
   byte7_zero_a: assert property (byte_valid && idx == 4'h7 |->
      byte_data == 8'h00) else $error("byte7 set");
   unsup_bit_a: assert property (byte_valid && idx == 4'h0 && frame_len != 4'h8
      |-> !byte_data[1]) else $error("bit1 set");
   hold_byte_a: assert property (byte_valid && !byte_ready |=>
      byte_valid && $stable(byte_data)) else $error("byte moved");
   poll_answer_a: assert property ($rose(byte_valid) |->
      $past(poll, 2)) else $error("unasked frame");
   err_ext_only_a: assert property (byte_valid && error_response |->
      frame_len == 4'h8) else $error("error flag");
endmodule // dsia_assembler_assertions
bind dsia_assembler dsia_assembler_assertions u_chk (.clock(clock),
   .rst(rst), .poll(poll), .byte_valid(byte_valid), .byte_ready(byte_ready),
   .byte_data(byte_data), .byte_last(byte_last),
   .error_response(error_response), .frame_len(frame_len));

// ===== dv/dsia_assembler_tb_top.sv
// bench for the status assembler: apb setup, frames against a model
// assumes the sink model and the bound checker
module dsia_assembler_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, poll = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, e, byte_valid, byte_ready, byte_last, err_o;
   logic [8:0] fl = 0;
   logic [15:0] sp = 0, pr = 0, cu = 0;
   logic [7:0] al = 0, lay, byte_data, b0;
   logic cmd_done = 0, last_err = 0;
   logic [5:0] cmd_fail = 0;
   logic [3:0] frame_len;
   logic [7:0] q[$];
   logic [7:0] codes[5] = '{8'h46, 8'h47, 8'hb0, 8'h96, 8'h12};
   int n_fail = 0, samples_checked = 0, cyc = 0, i;
   always #5 clock = ~clock;
   dsia_assembler dut (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_at_reference(fl[8]), .speed_ref_from_network(fl[7]),
      .control_from_network(fl[6]), .drive_ready(fl[5]),
      .rotating_rev(fl[4]), .rotating_fwd(fl[3]), .fault_state(fl[2]),
      .stall_prevention_active(fl[1]), .frequency_reached(fl[0]),
      .speed_actual(sp), .param_read_value(pr), .output_current(cu),
      .alarm_code(al), .cmd_done(cmd_done), .cmd_fail(cmd_fail),
      .poll(poll), .byte_valid(byte_valid), .byte_ready(byte_ready),
      .byte_data(byte_data), .byte_last(byte_last),
      .error_response(err_o), .frame_len(frame_len));
   dsia_sink_model sink (.clock(clock), .rst(rst), .byte_ready(byte_ready));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock) penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task automatic conclude();
      if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clock) if (++cyc == 20000) begin n_fail++; conclude(); end
   initial begin
      void'($urandom(32'hd810));
      repeat (19) @(posedge clock);
      @(negedge clock);
      chk({byte_valid, byte_last, err_o, frame_len, pready}, 8'h09);
      chk(prdata, 32'h0);
      @(posedge clock);
      rst <= 0;
      @(posedge clock) apb(0, 12'h000, 0); chk(r, 8'h47);
      apb(1, 12'hffc, 32'h96);
      apb(0, 12'hffc, 0);
      chk(e, 1'b1);
      chk(r, 32'h0);
      apb(0, 12'h000, 0);
      chk(r, 8'h47);
      for (int k = 0; k < 25; k++) begin
         lay = codes[k % 5];
         apb(1, 12'h000, {24'h0, lay});
         fl <= 9'($urandom);
         sp <= 16'($urandom);
         pr <= 16'($urandom);
         cu <= 16'($urandom);
         al <= 8'($urandom);
         if (k % 3 != 2) begin
            cmd_done <= 1;
            cmd_fail <= ($urandom % 2) ? 6'h1 << (k % 6) : 6'h0;
            @(posedge clock) cmd_done <= 0;
            last_err = cmd_fail != 0;
            apb(0, 12'h008, 0); chk(r[0], last_err);
         end
         poll <= 1;
         @(posedge clock) poll <= 0;
         b0 = {fl[8:3], 1'b0, fl[2]};
         case (lay)
            8'h46: q = '{{5'h0, fl[3], 2'h0}, 0, sp[7:0], sp[15:8]};
            8'hb0: q = '{b0, 0, sp[7:0], sp[15:8], pr[7:0], pr[15:8]};
            8'h96: q = '{{2'h0, fl[1:0], 1'b0, fl[2], fl[4:3]}, 0, sp[7:0],
               sp[15:8], cu[7:0], cu[15:8], al, 0};
            default: q = '{b0, 0, sp[7:0], sp[15:8]};
         endcase
         i = 0;
         while (i < q.size()) begin
            @(negedge clock);
            if (byte_valid && byte_ready) begin
               if (i == 0) chk({err_o, frame_len}, {lay == 8'h96 && last_err,
                  4'(q.size())});
               chk({byte_last, byte_data}, {i == q.size() - 1, q[i]});
               i++;
            end
            @(posedge clock);
            if (i > 0) fl <= 9'($urandom);
            poll <= (i == 2);
         end
         repeat (3) begin
            @(negedge clock);
            chk(byte_valid, 1'b0);
            @(posedge clock);
         end
         while (q.size() < 8) q.push_back(8'h00);
         apb(0, 12'h00c, 0);
         chk(r, {q[3], q[2], q[1], q[0]});
         apb(0, 12'h010, 0);
         chk(r, {q[7], q[6], q[5], q[4]});
         apb(0, 12'h004, 0);
         chk(r, {28'h0, dsia_pkg::DSIA_IDLE});
      end
      conclude();
   end
endmodule // dsia_assembler_tb_top

// ===== dv/dsia_sink_model.sv
// scanner side byte sink: accepts bytes, stalling at random
// assumes the bench seeds the random generator
module dsia_sink_model (
   input wire logic clock,
   input wire logic rst,
   output logic     byte_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clock or posedge rst) begin
      if (rst) byte_ready <= 1'b0;
      else byte_ready <= ($urandom % 4) != 0;
   end
endmodule // dsia_sink_model

// ===== src/dsia_apb_regs.sv
// apb slave holding layout select and exposing framer state
// assumes apb3 master on the same clock; zero wait states
`include "dsia_consts.svh"
module dsia_apb_regs (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [7:0]  layout,
   input  wire logic [7:0]  status_view,
   input  wire logic        cmd_error,
   input  wire logic [63:0] frame_view
);
   logic [31:0] next_rdata;
   wire         access  = psel & penable;
   wire         hit_lay = paddr == `DSIA_OFF_LAYOUT;
   wire         hit_sts = paddr == `DSIA_OFF_STATUS;
   wire         hit_err = paddr == `DSIA_OFF_CMDERR;
   wire         hit_flo = paddr == `DSIA_OFF_FRAME_LO;
   wire         hit_fhi = paddr == `DSIA_OFF_FRAME_HI;
   wire         mapped  = hit_lay | hit_sts | hit_err | hit_flo | hit_fhi;
   wire         wr_lay  = access & pwrite & hit_lay;
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign next_rdata = hit_lay ? {24'h000000, layout} :
                       hit_sts ? {24'h000000, status_view} :
                       hit_err ? {31'h00000000, cmd_error} :
                       hit_flo ? frame_view[31:0] :
                       hit_fhi ? frame_view[63:32] : 32'h00000000;
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         layout <= `DSIA_RST_LAYOUT;
      else if (wr_lay)
         layout <= pwdata[7:0];
   end
   always_comb begin
      prdata = (access & ~pwrite) ? next_rdata : 32'h00000000;
   end
endmodule // dsia_apb_regs

// ===== src/dsia_assembler.sv
// drive status input assembler: builds polled input frames
// assumes synchronous drive-core flags and a byte sink with ready
// Function
// R1: parameter layout frame is six bytes
// R2: master pairs parameter status with command
// R3: byte0 bit7 set at reference speed
// R4: byte0 bit6 speed reference from network
// R5: byte0 bit5 run commands from network
// R6: byte0 bit4 ready, bit1 always zero
// R7: byte0 bit3 rotating reverse
// R8: byte0 bit2 rotating forward
// R9: byte0 bit0 fault state
// R10: parameter byte1 zero, speed bytes 2-3
// R11: parameter read value in bytes 4-5
// R12: default layout four bytes, same flags
// R13: basic layout four bytes, forward flag
// R14: extended byte0 bit5 stall prevention
// R15: extended byte0 bit4 frequency reached
// R16: extended bits 2,1,0 trip, reverse, forward
// R17: extended current 4-5, code 6, zeros
// R18: extended speed low byte2, high byte3
// R19: command frame failure gives error response; the code flags it in the extended layout only
// R20: shutoff terminal needs function select six
// R21: master selects read parameter by class
// R22: snapshot all fields before each frame
//
// Implementation choices: the APB register port and the register offsets.
`include "dsia_consts.svh"
module dsia_assembler (
   input  wire logic        clock,
   input  wire logic        rst,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // drive core
   input  wire logic        speed_at_reference,
   input  wire logic        speed_ref_from_network,
   input  wire logic        control_from_network,
   input  wire logic        drive_ready,
   input  wire logic        rotating_rev,
   input  wire logic        rotating_fwd,
   input  wire logic        fault_state,
   input  wire logic        stall_prevention_active,
   input  wire logic        frequency_reached,
   input  wire logic [15:0] speed_actual,
   input  wire logic [15:0] param_read_value,
   input  wire logic [15:0] output_current,
   input  wire logic [7:0]  alarm_code,
   // outcome of the eight-byte command frame requests
   input  wire logic        cmd_done,
   input  wire logic [5:0]  cmd_fail,
   // frame request and byte stream toward the link
   input  wire logic        poll,
   output logic             byte_valid,
   input  wire logic        byte_ready,
   output logic      [7:0]  byte_data,
   output logic             byte_last,
   output logic             error_response,
   output logic      [3:0]  frame_len
);
   dsia_pkg::dsia_state_t state;
   dsia_pkg::dsia_state_t next_state;
   logic [7:0]  layout;
   logic [63:0] snap;
   logic [63:0] next_frame;
   logic [3:0]  next_len;
   logic [7:0]  status_view;
   logic        busy;
   logic        cmd_error;

   function automatic logic [7:0] drive_flags(
      input logic at_ref,
      input logic ref_net,
      input logic ctrl_net,
      input logic rdy,
      input logic rev,
      input logic fwd,
      input logic flt);
      logic [7:0] b;
      b = 8'h00;
      b[`DSIA_BIT_AT_REF]   = at_ref;   // [R3]
      b[`DSIA_BIT_REF_NET]  = ref_net;  // [R4]
      b[`DSIA_BIT_CTRL_NET] = ctrl_net; // [R5]
      b[`DSIA_BIT_READY]    = rdy;      // [R6]
      b[`DSIA_BIT_RUN_REV]  = rev;      // [R7]
      b[`DSIA_BIT_RUN_FWD]  = fwd;      // [R8]
      b[`DSIA_BIT_UNSUP]    = 1'b0;     // [R6]
      b[`DSIA_BIT_FAULT]    = flt;      // [R9]
      return b;
   endfunction

   wire [7:0] std_flags = drive_flags(
      speed_at_reference,
      speed_ref_from_network,
      control_from_network,
      drive_ready,
      rotating_rev,
      rotating_fwd,
      fault_state);

   logic [7:0] ext_flags;
   always_comb begin
      ext_flags = 8'h00;
      ext_flags[`DSIA_XBIT_STALL] = stall_prevention_active; // [R14]
      ext_flags[`DSIA_XBIT_FREQ]  = frequency_reached;       // [R15]
      ext_flags[`DSIA_XBIT_TRIP]  = fault_state;             // [R16]
      ext_flags[`DSIA_XBIT_REV]   = rotating_rev;            // [R16]
      ext_flags[`DSIA_XBIT_FWD]   = rotating_fwd;            // [R16]
   end

   logic [7:0] basic_flags;
   always_comb begin
      basic_flags = 8'h00;
      basic_flags[`DSIA_BIT_BASIC_FWD] = rotating_fwd; // [R13]
   end

   // packs eight bytes with byte 0 in the low lane, sent first
   function automatic logic [63:0] pack_bytes(
      input logic [7:0] b0,
      input logic [7:0] b1,
      input logic [7:0] b2,
      input logic [7:0] b3,
      input logic [7:0] b4,
      input logic [7:0] b5,
      input logic [7:0] b6,
      input logic [7:0] b7);
      return {b7, b6, b5, b4, b3, b2, b1, b0};
   endfunction

   // byte count of a layout; unknown codes fall back to the default frame
   function automatic logic [3:0] layout_len(input logic [7:0] code);
      logic [3:0] n;
      unique case (code)
         `DSIA_LAYOUT_BASIC: n = `DSIA_LEN_BASIC;   // [R13]
         `DSIA_LAYOUT_PARAM: n = `DSIA_LEN_PARAM;   // [R1]
         `DSIA_LAYOUT_EXT:   n = `DSIA_LEN_EXT;
         default:            n = `DSIA_LEN_DEFAULT; // [R12]
      endcase
      return n;
   endfunction

   wire        sel_basic = (layout == `DSIA_LAYOUT_BASIC);
   wire        sel_param = (layout == `DSIA_LAYOUT_PARAM);
   wire        sel_ext   = (layout == `DSIA_LAYOUT_EXT);

   // byte lanes shared by the layouts
   wire [7:0]  zero_byte  = 8'h00;
   wire [7:0]  speed_lo   = speed_actual[7:0];
   wire [7:0]  speed_hi   = speed_actual[15:8];
   wire [7:0]  param_lo   = param_read_value[7:0];
   wire [7:0]  param_hi   = param_read_value[15:8];
   wire [7:0]  current_lo = output_current[7:0];
   wire [7:0]  current_hi = output_current[15:8];

   wire [63:0] basic_frame = pack_bytes(
      basic_flags,  // [R13]
      zero_byte,
      speed_lo,
      speed_hi,
      zero_byte,
      zero_byte,
      zero_byte,
      zero_byte);

   wire [63:0] dflt_frame = pack_bytes(
      std_flags,    // [R12]
      zero_byte,
      speed_lo,
      speed_hi,
      zero_byte,
      zero_byte,
      zero_byte,
      zero_byte);

   wire [63:0] param_frame = pack_bytes(
      std_flags,
      zero_byte,    // [R10]
      speed_lo,     // [R10]
      speed_hi,
      param_lo,     // [R11]
      param_hi,
      zero_byte,
      zero_byte);

   wire [63:0] ext_frame = pack_bytes(
      ext_flags,
      zero_byte,    // [R17]
      speed_lo,     // [R18]
      speed_hi,
      current_lo,   // [R17]
      current_hi,
      alarm_code,   // [R17]
      zero_byte);   // [R17]

   assign next_frame = sel_basic ? basic_frame :
                       sel_param ? param_frame :
                       sel_ext   ? ext_frame   : dflt_frame;
   assign next_len   = layout_len(layout); // [R1]

   wire start = (state == dsia_pkg::DSIA_SNAP);

   always_comb begin
      unique case (state)
         dsia_pkg::DSIA_IDLE: begin
            if (poll)
               next_state = dsia_pkg::DSIA_SNAP;
            else
               next_state = dsia_pkg::DSIA_IDLE;
         end
         dsia_pkg::DSIA_SNAP: begin
            next_state = dsia_pkg::DSIA_SEND;
         end
         dsia_pkg::DSIA_SEND: begin
            if (busy)
               next_state = dsia_pkg::DSIA_SEND;
            else
               next_state = dsia_pkg::DSIA_DONE;
         end
         dsia_pkg::DSIA_DONE: begin
            next_state = dsia_pkg::DSIA_IDLE;
         end
         default: begin
            next_state = dsia_pkg::DSIA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         state <= dsia_pkg::DSIA_IDLE;
      else
         state <= next_state;
   end

   // one coherent capture per frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         snap      <= 64'h0;
         frame_len <= `DSIA_LEN_DEFAULT;
      end else if (start) begin
         snap      <= next_frame; // [R22]
         frame_len <= next_len;   // [R1]
      end
   end

   // one failure bit per request of the eight-byte command frame
   wire fail_shutoff = cmd_fail[`DSIA_FAIL_SHUTOFF];
   wire fail_reset   = cmd_fail[`DSIA_FAIL_RESET];
   wire fail_dir     = cmd_fail[`DSIA_FAIL_DIR];
   wire fail_speed   = cmd_fail[`DSIA_FAIL_SPEED];
   wire fail_accel   = cmd_fail[`DSIA_FAIL_ACCEL];
   wire fail_decel   = cmd_fail[`DSIA_FAIL_DECEL];
   wire any_fail     = fail_shutoff | fail_reset | fail_dir |
                       fail_speed | fail_accel | fail_decel; // [R19]

   // any failed request of the last completed command frame makes each extended-layout answer an error
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         cmd_error <= 1'b0;
      else if (cmd_done)
         cmd_error <= any_fail; // [R19]
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         error_response <= 1'b0;
      else if (start)
         error_response <= cmd_error & sel_ext; // [R19]
   end

   assign status_view = {4'h0, state};

   dsia_serializer u_ser (
      .clock      (clock),
      .rst        (rst),
      .load       (start),
      .frame      (next_frame),
      .len        (frame_len),
      .busy       (busy),
      .byte_valid (byte_valid),
      .byte_ready (byte_ready),
      .byte_data  (byte_data),
      .byte_last  (byte_last)
   );

   dsia_apb_regs u_regs (
      .clock       (clock),
      .rst         (rst),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .layout      (layout),
      .status_view (status_view),
      .cmd_error   (cmd_error),
      .frame_view  (snap)
   );
endmodule // dsia_assembler

// ===== src/dsia_consts.svh
// constants for the drive status input assembler
// assumes inclusion by bare name from design files
`ifndef DSIA_CONSTS_SVH
`define DSIA_CONSTS_SVH
`define DSIA_LAYOUT_BASIC    8'h46
`define DSIA_LAYOUT_DEFAULT  8'h47
`define DSIA_LAYOUT_PARAM    8'hb0
`define DSIA_LAYOUT_EXT      8'h96
`define DSIA_LEN_BASIC       4'h4
`define DSIA_LEN_DEFAULT     4'h4
`define DSIA_LEN_PARAM       4'h6
`define DSIA_LEN_EXT         4'h8
`define DSIA_OFF_LAYOUT      12'h000
`define DSIA_OFF_STATUS      12'h004
`define DSIA_OFF_CMDERR      12'h008
`define DSIA_OFF_FRAME_LO    12'h00c
`define DSIA_OFF_FRAME_HI    12'h010
`define DSIA_RST_LAYOUT      8'h47
`define DSIA_BIT_AT_REF      7
`define DSIA_BIT_REF_NET     6
`define DSIA_BIT_CTRL_NET    5
`define DSIA_BIT_READY       4
`define DSIA_BIT_RUN_REV     3
`define DSIA_BIT_RUN_FWD     2
`define DSIA_BIT_UNSUP       1
`define DSIA_BIT_FAULT       0
`define DSIA_XBIT_STALL      5
`define DSIA_XBIT_FREQ       4
`define DSIA_XBIT_TRIP       2
`define DSIA_XBIT_REV        1
`define DSIA_XBIT_FWD        0
`define DSIA_BIT_BASIC_FWD   2
`define DSIA_FAIL_SHUTOFF    0
`define DSIA_FAIL_RESET      1
`define DSIA_FAIL_DIR        2
`define DSIA_FAIL_SPEED      3
`define DSIA_FAIL_ACCEL      4
`define DSIA_FAIL_DECEL      5
`endif

// ===== src/dsia_pkg.sv
// types for the drive status input assembler
// assumes nothing beyond a SystemVerilog compiler
package dsia_pkg;
   typedef enum logic [3:0] {
      DSIA_IDLE = 4'b0001,
      DSIA_SNAP = 4'b0010,
      DSIA_SEND = 4'b0100,
      DSIA_DONE = 4'b1000
   } dsia_state_t;
   typedef logic [7:0] dsia_byte_t;
endpackage

// ===== src/dsia_serializer.sv
// shifts a snapshotted frame out one byte per ready cycle
// assumes length stays fixed while busy; the frame is copied at load
`include "dsia_consts.svh"
module dsia_serializer (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [63:0] frame,
   input  wire logic [3:0]  len,
   output logic             busy,
   output logic             byte_valid,
   input  wire logic        byte_ready,
   output logic      [7:0]  byte_data,
   output logic             byte_last
);
   logic [3:0]  idx;
   logic [63:0] hold;
   wire         fire = byte_valid & byte_ready;
   wire         end_ = fire & (idx == len - 4'h1);
   assign byte_valid = busy;
   assign byte_last  = busy & (idx == len - 4'h1);
   always_comb begin
      byte_data = hold[7:0];
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         idx  <= 4'h0;
         hold <= 64'h0;
      end else if (load) begin
         busy <= 1'b1;
         idx  <= 4'h0;
         hold <= frame;
      end else if (fire) begin
         busy <= ~end_;
         idx  <= idx + 4'h1;
         hold <= {8'h00, hold[63:8]};
      end
   end
endmodule // dsia_serializer
